/* File: shared/ird_map.svh */
// Register offsets, field positions and reset values of the infrared receive decoder.
// Assumes inclusion by bare name from the decoder file and the bench.
`ifndef IRD_MAP_SVH
`define IRD_MAP_SVH
`define IRD_OFS_CTRL 4'h0
`define IRD_OFS_PRESC 4'h1
`define IRD_OFS_GUIDE_LO 4'h2
`define IRD_OFS_GUIDE_HI 4'h3
`define IRD_OFS_ZERO_LO 4'h4
`define IRD_OFS_ZERO_HI 4'h5
`define IRD_OFS_ONE_LO 4'h6
`define IRD_OFS_ONE_HI 4'h7
`define IRD_OFS_STATUS 4'h8
`define IRD_OFS_SHIFT 4'h9
`define IRD_OFS_DATA 4'hA
`define IRD_CTRL_RUN 0
`define IRD_CTRL_FMT_LSB 1
`define IRD_CTRL_DIR 4
`define IRD_ST_GOK 0
`define IRD_ST_FULL 1
`define IRD_ST_DERR 2
`define IRD_ST_END 3
`define IRD_ST_HOLD 4
`define IRD_RST_BYTE 8'h00
`define IRD_CNT_MAX 6'h3F
`define IRD_MULT_PPM 6'h04
`define IRD_MULT_MAN 6'h02
`define IRD_LAST_BIT 3'h7
`endif

/* File: shared/ird_pkg.sv */
// Types shared by the infrared receive decoder.
// Assumes nothing of its surroundings.
package ird_pkg;
   typedef enum logic [1:0] {
      IRD_IDLE = 2'b00,
      IRD_GUIDE = 2'b01,
      IRD_DATA = 2'b11,
      IRD_HOLD = 2'b10
   } ird_state_e;
   typedef enum logic [2:0] {
      IRD_FMT_A = 3'h0,
      IRD_FMT_B = 3'h1,
      IRD_FMT_C = 3'h2,
      IRD_FMT_D = 3'h3
   } ird_fmt_e;
endpackage

/* File: hdl/ird_decoder.sv */
// Infrared remote receive decoder: PPM formats A, B, C and Manchester format D.
// Assumes a register master that keeps strobes one cycle long and never both at once.
`include "ird_map.svh"

module ird_decoder (
   // Clock and reset.
   input wire logic clk,
   input wire logic srst,
   // Register port.
   input wire logic [3:0] addr,
   input wire logic [7:0] wdata,
   input wire logic we,
   input wire logic re,
   output logic [7:0] rdata,
   // Demodulated remote input.
   input wire logic ir_in
);
   import ird_pkg::*;

   logic [7:0] ctrl_q, presc_q, rdata_q, rx_shift_register_q, rx_data_register_q;
   logic [4:0] guide_low_limit_q, guide_high_limit_q, zero_low_limit_q;
   logic [4:0] zero_high_limit_q, one_low_limit_q, one_high_limit_q;
   logic [2:0] rx_bit_counter_q;
   logic [5:0] majority_counter_q, mult_q;
   logic [7:0] base_q;
   logic [2:0] sync_q;
   logic guide_ok_flag_q, byte_full_flag_q, data_error_flag_q, rx_end_flag_q;
   logic first_q, first_d, srch_q, srch_d, samp1_q, samp1_d, samp3_q, samp3_d;
   logic clr_cnt, start_rx, gok_set, bit_ok, bit_val, derr_set, end_set;
   ird_state_e st_q, st_d;

   // Register decode.
   wire wr_ctrl = we && addr == `IRD_OFS_CTRL;
   wire wr_presc = we && addr == `IRD_OFS_PRESC;
   wire wr_stat = we && addr == `IRD_OFS_STATUS;
   wire sr_read = re && addr == `IRD_OFS_SHIFT;
   wire rx_run = ctrl_q[`IRD_CTRL_RUN];
   wire shift_direction = ctrl_q[`IRD_CTRL_DIR];
   wire [2:0] fmt = ctrl_q[`IRD_CTRL_FMT_LSB +: 3];
   wire is_a = fmt == IRD_FMT_A;
   wire is_b = fmt == IRD_FMT_B;
   wire is_c = fmt == IRD_FMT_C;
   wire is_d = fmt == IRD_FMT_D;
   wire rx_hold_flag = st_q == IRD_HOLD;
   wire [2:0] tick_period_select = presc_q[2:0];
   wire [1:0] guide_prescale_count = presc_q[7:6];
   wire [1:0] data_prescale_count = presc_q[5:4];

   // Edge detection on the synchronised input.
   wire in_s = sync_q[1];
   wire rise = sync_q[1] && !sync_q[2];
   wire fall = !sync_q[1] && sync_q[2];
   wire any_edge = rise || fall;
   wire q_edge = is_a ? fall : rise;

   // Time base: the base period is 2^select clocks, times the format multiplier shifted left by the prescale count.
   wire data_mode = st_q == IRD_DATA;
   wire [1:0] pc_sel = data_mode ? data_prescale_count : guide_prescale_count;
   wire [5:0] mult_base = (fmt >= IRD_FMT_D) ? `IRD_MULT_MAN : `IRD_MULT_PPM;
   wire [5:0] mult_max = 6'((mult_base << pc_sel) - 6'h01);
   wire [7:0] base_max = 8'((8'h01 << tick_period_select) - 8'h01);
   wire base_hit = base_q == base_max;
   wire measure_tick = base_hit && mult_q == mult_max;
   wire [5:0] cnt = majority_counter_q;

   // Window comparisons; a limit L means L + 1 ticks.
   wire g_win = cnt > {1'b0, guide_low_limit_q} && cnt <= {1'b0, guide_high_limit_q};
   wire z_win = cnt > {1'b0, zero_low_limit_q} && cnt <= {1'b0, zero_high_limit_q};
   wire o_win = cnt > {1'b0, one_low_limit_q} && cnt <= {1'b0, one_high_limit_q};
   wire over = cnt > {1'b0, one_high_limit_q};
   wire t1 = measure_tick && cnt == {1'b0, zero_low_limit_q};
   wire t2 = measure_tick && cnt == {1'b0, zero_high_limit_q};
   wire t3 = measure_tick && cnt == {1'b0, one_low_limit_q};
   wire t4 = measure_tick && cnt == {1'b0, one_high_limit_q};
   wire d_bad = first_q ? !samp1_q : samp1_q == samp3_q;

   // Shift path.
   wire [7:0] sr_next = shift_direction ? {rx_shift_register_q[6:0], bit_val}
                                        : {bit_val, rx_shift_register_q[7:1]};
   wire byte_done = bit_ok && rx_bit_counter_q == `IRD_LAST_BIT;
   wire [7:0] status = {rx_hold_flag, rx_end_flag_q, data_error_flag_q, byte_full_flag_q,
                        guide_ok_flag_q, rx_bit_counter_q};

   // Read selection.
   wire [7:0] rd_mux =
      addr == `IRD_OFS_CTRL ? ctrl_q :
      addr == `IRD_OFS_PRESC ? presc_q :
      addr == `IRD_OFS_GUIDE_LO ? {3'h0, guide_low_limit_q} :
      addr == `IRD_OFS_GUIDE_HI ? {3'h0, guide_high_limit_q} :
      addr == `IRD_OFS_ZERO_LO ? {3'h0, zero_low_limit_q} :
      addr == `IRD_OFS_ZERO_HI ? {3'h0, zero_high_limit_q} :
      addr == `IRD_OFS_ONE_LO ? {3'h0, one_low_limit_q} :
      addr == `IRD_OFS_ONE_HI ? {3'h0, one_high_limit_q} :
      addr == `IRD_OFS_STATUS ? status :
      addr == `IRD_OFS_SHIFT ? rx_shift_register_q :
      addr == `IRD_OFS_DATA ? rx_data_register_q : `IRD_RST_BYTE;
   assign rdata = rdata_q;

   always_comb begin
      st_d = st_q;
      {clr_cnt, start_rx, gok_set, bit_ok, bit_val, derr_set, end_set} = 7'h00;
      {first_d, srch_d, samp1_d, samp3_d} = {first_q, srch_q, samp1_q, samp3_q};
      unique case (st_q)
         IRD_IDLE: begin
            if (rise && fmt <= IRD_FMT_D) begin
               clr_cnt = 1'b1;
               if (is_c || is_d) begin
                  start_rx = 1'b1;
                  first_d = 1'b1;
                  srch_d = 1'b0;
                  st_d = IRD_DATA;
               end else begin
                  st_d = IRD_GUIDE;
               end
            end
         end
         IRD_GUIDE: begin
            if ((is_a && fall) || (is_b && rise)) begin
               clr_cnt = 1'b1;
               if (g_win) begin
                  gok_set = 1'b1;
                  start_rx = 1'b1;
                  st_d = IRD_DATA;
               end else begin
                  // A failed rising-edge guide restarts measurement at this edge.
                  st_d = is_b ? IRD_GUIDE : IRD_IDLE;
               end
            end
         end
         IRD_DATA: begin
            if (is_d) begin
               if (t1) begin
                  samp1_d = in_s;
               end
               if (t2) begin
                  bit_val = samp1_q;
                  if (d_bad) begin
                     derr_set = 1'b1;
                     st_d = IRD_IDLE;
                  end else begin
                     bit_ok = 1'b1;
                  end
               end
               if (t3) begin
                  samp3_d = in_s;
                  srch_d = 1'b1;
               end
               if (srch_q && any_edge) begin
                  clr_cnt = 1'b1;
                  srch_d = 1'b0;
                  first_d = 1'b0;
               end else if (t4) begin
                  end_set = 1'b1;
               end
            end else if (q_edge) begin
               clr_cnt = 1'b1;
               bit_val = o_win;
               if (z_win || o_win) begin
                  bit_ok = 1'b1;
               end else begin
                  derr_set = 1'b1;
                  st_d = IRD_IDLE;
               end
            end else if (over) begin
               end_set = 1'b1;
            end
            if (end_set) begin
               st_d = IRD_HOLD;
            end
         end
         IRD_HOLD: begin
            if (sr_read) begin
               st_d = IRD_IDLE;
            end
         end
      endcase
      if (!rx_run) begin
         st_d = IRD_IDLE;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         sync_q <= 3'h0;
      end else begin
         sync_q <= {sync_q[1:0], ir_in};
      end
   end

   always_ff @(posedge clk) begin
      if (srst || clr_cnt) begin
         base_q <= 8'h00;
         mult_q <= 6'h00;
      end else if (base_hit) begin
         base_q <= 8'h00;
         mult_q <= measure_tick ? 6'h00 : 6'(mult_q + 6'h01);
      end else begin
         base_q <= 8'(base_q + 8'h01);
      end
   end

   always_ff @(posedge clk) begin
      if (srst || clr_cnt) begin
         majority_counter_q <= 6'h00;
      end else if (measure_tick && majority_counter_q != `IRD_CNT_MAX) begin
         majority_counter_q <= 6'(majority_counter_q + 6'h01);
      end
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         st_q <= IRD_IDLE;
         {first_q, srch_q, samp1_q, samp3_q} <= 4'h0;
      end else begin
         st_q <= st_d;
         {first_q, srch_q, samp1_q, samp3_q} <= {first_d, srch_d, samp1_d, samp3_d};
      end
   end

   always_ff @(posedge clk) begin
      if (srst || !rx_run || start_rx) begin
         rx_shift_register_q <= `IRD_RST_BYTE;
         rx_bit_counter_q <= 3'h0;
      end else if (bit_ok) begin
         rx_bit_counter_q <= 3'(rx_bit_counter_q + 3'h1);
         rx_shift_register_q <= byte_done ? `IRD_RST_BYTE : sr_next;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         rx_data_register_q <= `IRD_RST_BYTE;
      end else if (byte_done) begin
         rx_data_register_q <= sr_next;
      end
   end
   // Sticky flags: software writes one to clear, a same-cycle set wins.
   always_ff @(posedge clk) begin
      if (srst) begin
         {guide_ok_flag_q, byte_full_flag_q, data_error_flag_q, rx_end_flag_q} <= 4'h0;
      end else begin
         guide_ok_flag_q <= gok_set || (guide_ok_flag_q && !(wr_stat && wdata[`IRD_ST_GOK]));
         byte_full_flag_q <= byte_done || (byte_full_flag_q && !(wr_stat && wdata[`IRD_ST_FULL]));
         data_error_flag_q <= derr_set || (data_error_flag_q && !(wr_stat && wdata[`IRD_ST_DERR]));
         rx_end_flag_q <= end_set || (rx_end_flag_q && !(wr_stat && wdata[`IRD_ST_END]));
      end
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         {ctrl_q, presc_q, rdata_q} <= {3{`IRD_RST_BYTE}};
      end else begin
         if (wr_ctrl) ctrl_q <= wdata;
         if (wr_presc) presc_q <= wdata;
         rdata_q <= re ? rd_mux : `IRD_RST_BYTE;
      end
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         {guide_low_limit_q, guide_high_limit_q, zero_low_limit_q} <= 15'h0000;
         {zero_high_limit_q, one_low_limit_q, one_high_limit_q} <= 15'h0000;
      end else if (we) begin
         if (addr == `IRD_OFS_GUIDE_LO) guide_low_limit_q <= wdata[4:0];
         if (addr == `IRD_OFS_GUIDE_HI) guide_high_limit_q <= wdata[4:0];
         if (addr == `IRD_OFS_ZERO_LO) zero_low_limit_q <= wdata[4:0];
         if (addr == `IRD_OFS_ZERO_HI) zero_high_limit_q <= wdata[4:0];
         if (addr == `IRD_OFS_ONE_LO) one_low_limit_q <= wdata[4:0];
         if (addr == `IRD_OFS_ONE_HI) one_high_limit_q <= wdata[4:0];
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (srst);

   AST_GUIDE_OK: assert property (
      st_q == IRD_GUIDE && is_a && fall && g_win && rx_run
      |=> st_q == IRD_DATA && guide_ok_flag_q && rx_bit_counter_q == 3'h0)
      else $error("Valid guide not accepted.");
   AST_GUIDE_BAD: assert property (
      st_q == IRD_GUIDE && is_a && fall && !g_win |=> st_q == IRD_IDLE)
      else $error("Bad guide not rejected.");
   AST_BIT_COUNT: assert property (
      st_q == IRD_DATA && !is_d && q_edge && (z_win || o_win) && rx_run
      |=> rx_bit_counter_q == 3'($past(rx_bit_counter_q) + 3'h1))
      else $error("Bit counter did not advance.");
   AST_DATA_ERR: assert property (
      st_q == IRD_DATA && !is_d && q_edge && !z_win && !o_win
      |=> data_error_flag_q && st_q == IRD_IDLE)
      else $error("Bad data pulse not flagged.");
   AST_END: assert property (
      st_q == IRD_DATA && !is_d && !q_edge && over && rx_run
      |=> rx_end_flag_q && rx_hold_flag)
      else $error("End of reception missed.");
   AST_HOLD_KEEP: assert property (
      rx_hold_flag && !sr_read && rx_run |=> rx_hold_flag)
      else $error("Hold left without shift read.");
   AST_RUN_CLEAR: assert property (
      !rx_run |=> rx_shift_register_q == 8'h00 && rx_bit_counter_q == 3'h0 && !rx_hold_flag)
      else $error("Run clear left state behind.");
   AST_BYTE: assert property (
      byte_done && rx_run |=> byte_full_flag_q && rx_data_register_q == $past(sr_next)
      && rx_shift_register_q == 8'h00)
      else $error("Byte transfer wrong.");
   AST_LSB: assert property (
      bit_ok && !shift_direction && !byte_done && rx_run && !start_rx
      |=> rx_shift_register_q[7] == $past(bit_val))
      else $error("LSB-first shift wrong.");
   AST_D_FIRST: assert property (
      st_q == IRD_DATA && is_d && first_q && t2 && !samp1_q |=> data_error_flag_q ##0 !data_mode)
      else $error("First Manchester bit low not flagged.");
   COV_GUIDE: cover property (gok_set);
   COV_BYTE: cover property (byte_done);
   COV_END: cover property (end_set ##[1:100] sr_read);
   COV_D_BIT: cover property (is_d && bit_ok);
endmodule

/* File: dv/ird_ir_source.sv */
// Behavioural remote-control source that drives the demodulated infrared line.
// Assumes the bench calls its tasks hierarchically, right after a rising clock edge.
module ird_ir_source (
   // Clock.
   input wire logic clk,
   // Demodulated remote line, idle low.
   output logic ir_line
);
   timeunit 1ns;
   timeprecision 1ps;

   initial ir_line = 1'b0;

   // Line high for hi clocks, then low for lo clocks.
   task automatic mark(input int hi, input int lo);
      ir_line <= 1'b1;
      repeat (hi) @(posedge clk);
      ir_line <= 1'b0;
      repeat (lo) @(posedge clk);
   endtask

   // Pulse-position frame, bits[n-1] sent first; fmt 0, 1 and 2 select A, B and C.
   // A zero spans 48 clocks and a one 80 clocks between measuring edges.
   task automatic ppm_frame(input int fmt, input logic [15:0] bits, input int n);
      int k;
      k = n - 1;
      if (fmt == 0) begin
         mark(48, bits[k] ? 64 : 32);
         k--;
      end else if (fmt == 1) begin
         mark(16, 32);
      end
      for (int i = k; i >= 0; i--) begin
         mark(16, bits[i] ? 64 : 32);
      end
      mark(16, 200);
   endtask

   // Manchester frame with a 32-clock bit; the first bit must be a one.
   task automatic man_frame(input logic [15:0] bits, input int n);
      ir_line <= 1'b1;
      repeat (16) @(posedge clk);
      for (int i = n - 2; i >= 0; i--) begin
         ir_line <= ~bits[i];
         repeat (16) @(posedge clk);
         ir_line <= bits[i];
         repeat (16) @(posedge clk);
      end
      repeat (80) @(posedge clk);
      ir_line <= 1'b0;
      repeat (4) @(posedge clk);
   endtask
endmodule

/* File: dv/tb_ir_remote_pulse_decoder.sv */
// Self-checking bench for the infrared receive decoder.
// Assumes the decoder, its package and the behavioural source; one 100 MHz clock.
`include "ird_map.svh"
module tb_ir_remote_pulse_decoder;
   timeunit 1ns;
   timeprecision 1ps;
   import ird_pkg::*;

   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00;
   logic we = 1'b0;
   logic re = 1'b0;
   logic [7:0] rdata;
   logic ir_line;
   logic [7:0] rv;
   int err_count = 0;
   int checks_done = 0;
   int cyc = 0;

   always #5 clk = ~clk;

   ird_decoder dut (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .we(we), .re(re),
      .rdata(rdata), .ir_in(ir_line));
   ird_ir_source src (.clk(clk), .ir_line(ir_line));

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         err_count++;
         $display("[FAIL] run time expected finish seen hang");
         tally_and_finish();
      end
   end

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      we <= 1'b1;
      @(posedge clk);
      we <= 1'b0;
   endtask

   // Read data is taken in the one cycle that follows the strobe cycle.
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      re <= 1'b1;
      @(posedge clk);
      re <= 1'b0;
      @(posedge clk);
      d = rdata;
   endtask

   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic rchk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e,
      input string name);
      rd(a, rv);
      chk(name, e, rv & m);
   endtask

   task automatic set_lim(input logic [7:0] gl, gh, zl, zh, ol, oh);
      wr(`IRD_OFS_PRESC, 8'h00);
      wr(`IRD_OFS_GUIDE_LO, gl);
      wr(`IRD_OFS_GUIDE_HI, gh);
      wr(`IRD_OFS_ZERO_LO, zl);
      wr(`IRD_OFS_ZERO_HI, zh);
      wr(`IRD_OFS_ONE_LO, ol);
      wr(`IRD_OFS_ONE_HI, oh);
   endtask

   // Clears the sticky flags, then selects format and direction with run set.
   task automatic start(input logic [7:0] ctrl);
      wr(`IRD_OFS_STATUS, 8'h0F);
      wr(`IRD_OFS_CTRL, ctrl);
   endtask

   task automatic t_reset();
      wr(4'hF, 8'hAA);
      rchk(`IRD_OFS_CTRL, 8'hFF, 8'h00, "ctrl after reset");
      rchk(`IRD_OFS_STATUS, 8'hFF, 8'h00, "status after reset");
      rchk(4'hF, 8'hFF, 8'h00, "unmapped read");
      chk("idle read data", 8'h00, rdata);
      $display("test reset done");
   endtask

   task automatic t_fmt_a();
      set_lim(8'h08, 8'h10, 8'h08, 8'h10, 8'h10, 8'h18);
      start({3'h0, 1'b1, IRD_FMT_A, 1'b1});
      src.ppm_frame(0, 16'h0396, 10);
      rchk(`IRD_OFS_STATUS, 8'hFF, 8'hDA, "status A");
      rchk(`IRD_OFS_DATA, 8'hFF, 8'hE5, "data A");
      rchk(`IRD_OFS_SHIFT, 8'hFF, 8'h02, "shift A partial");
      rchk(`IRD_OFS_STATUS, 8'h80, 8'h00, "hold after shift read");
      $display("test format A done");
   endtask

   task automatic t_fmt_b();
      start({3'h0, 1'b0, IRD_FMT_B, 1'b1});
      src.ppm_frame(1, 16'h00B8, 8);
      rchk(`IRD_OFS_STATUS, 8'hFF, 8'hD8, "status B");
      rchk(`IRD_OFS_DATA, 8'hFF, 8'h1D, "data B lsb first");
      rchk(`IRD_OFS_SHIFT, 8'hFF, 8'h00, "shift B after byte");
      $display("test format B done");
   endtask

   task automatic t_fmt_c();
      start({3'h0, 1'b1, IRD_FMT_C, 1'b1});
      src.mark(16, 32);
      src.mark(16, 32);
      src.mark(16, 16);
      src.mark(16, 200);
      rchk(`IRD_OFS_STATUS, 8'hE0, 8'h20, "status C error");
      rchk(`IRD_OFS_STATUS, 8'h07, 8'h02, "bits before error");
      start({3'h0, 1'b1, IRD_FMT_C, 1'b1});
      src.ppm_frame(2, 16'h0096, 8);
      rchk(`IRD_OFS_STATUS, 8'hFF, 8'hD0, "status C");
      rchk(`IRD_OFS_DATA, 8'hFF, 8'h96, "data C");
      rchk(`IRD_OFS_SHIFT, 8'hFF, 8'h00, "shift C");
      $display("test format C done");
   endtask

   task automatic t_run_clear();
      start({3'h0, 1'b1, IRD_FMT_A, 1'b1});
      src.ppm_frame(0, 16'h0005, 3);
      rchk(`IRD_OFS_STATUS, 8'h87, 8'h83, "hold before stop");
      wr(`IRD_OFS_CTRL, 8'h00);
      rchk(`IRD_OFS_STATUS, 8'h87, 8'h00, "status after stop");
      rchk(`IRD_OFS_SHIFT, 8'hFF, 8'h00, "shift after stop");
      $display("test run clear done");
   endtask

   // Guide tick 16 clocks, data tick 8 clocks: a swapped or ignored count misses the guide window of the first mark.
   task automatic t_presc();
      wr(`IRD_OFS_PRESC, 8'h41);
      start({3'h0, 1'b0, IRD_FMT_B, 1'b1});
      src.mark(32, 160);
      src.mark(32, 128);
      src.mark(32, 64);
      src.mark(32, 128);
      src.mark(32, 400);
      rchk(`IRD_OFS_STATUS, 8'hFF, 8'hCB, "status prescaled");
      rchk(`IRD_OFS_SHIFT, 8'hFF, 8'hA0, "shift prescaled");
      $display("test prescale done");
   endtask

   task automatic t_fmt_d();
      set_lim(8'h08, 8'h10, 8'h04, 8'h08, 8'h0C, 8'h13);
      start({3'h0, 1'b1, IRD_FMT_D, 1'b1});
      src.man_frame(16'h00B2, 8);
      rchk(`IRD_OFS_STATUS, 8'hFF, 8'hD0, "status D");
      rchk(`IRD_OFS_DATA, 8'hFF, 8'hB2, "data D");
      rchk(`IRD_OFS_SHIFT, 8'hFF, 8'h00, "shift D");
      start({3'h0, 1'b1, IRD_FMT_D, 1'b1});
      src.mark(4, 80);
      rchk(`IRD_OFS_STATUS, 8'hE0, 8'h20, "D first bit low");
      start({3'h0, 1'b1, IRD_FMT_D, 1'b1});
      src.mark(16, 16);
      src.mark(4, 80);
      rchk(`IRD_OFS_STATUS, 8'hE0, 8'h20, "D equal samples");
      $display("test format D done");
   endtask

   initial begin
      repeat (16) @(posedge clk);
      srst <= 1'b0;
      t_reset();
      t_fmt_a();
      t_fmt_b();
      t_fmt_c();
      t_run_clear();
      t_presc();
      t_fmt_d();
      tally_and_finish();
   end
endmodule
